// [rtl/serial_port_ctrl_status_brg.sv]
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - sync: clock source bit selects master/slave
// - transmit nine bit selects nine-bit characters
// - transmit enable, overridden by sync receive
// - mode select bit chooses synchronous operation
// - high rate bit picks async multiplier
// - shift empty status read-only, resets to one
// - transmit ninth data supplies ninth bit
// - port enable gives pins, clear holds reset
// - receive nine bit selects nine-bit reception
// - single receive, cleared when reception done
// - continuous receive enables, overrides single
// - address detect keeps ninth-bit-set characters only, in async nine-bit mode
// - framing flag follows top buffered character
// - overrun flag cleared by clearing continuous
// - receive ninth data follows top character
// - free-running 8-bit baud timer with divisor
// - multiplier follows high rate only async
// - divisor write clears baud timer at once
// - receive flag: enabled and unread character
// - two-character buffer, third causes overrun
module serial_port_ctrl_status_brg
    import serial_port_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // AXI4-Lite slave
    input wire logic [7:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [7:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    // shift engine side
    input wire logic i_tsr_empty,
    input wire logic i_rx_char_valid,
    input wire logic [7:0] i_rx_char_data,
    input wire logic i_rx_char_ninth,
    input wire logic i_rx_char_framing_error_flag,
    input wire logic i_rx_single_done,
    output logic o_port_enable,
    output logic o_sync_mode,
    output logic o_clock_master,
    output logic o_tx_enable,
    output logic o_tx_nine_bit,
    output logic o_tx_ninth_data,
    output logic o_rx_enable,
    output logic o_rx_nine_bit,
    output logic o_receive_flag,
    output logic o_baud_tick,
    output logic [1:0] o_baud_mult
);

    // ====================
    // address decode
    function automatic logic [2:0] reg_sel(input logic [7:0] addr);
        logic [2:0] sel;
        sel = SEL_NONE;
        case (addr)
            ADDR_TX_CS: sel = SEL_TX_CS;
            ADDR_RX_CS: sel = SEL_RX_CS;
            ADDR_RX_DATA: sel = SEL_RX_DATA;
            ADDR_BAUD_DIV: sel = SEL_BAUD_DIV;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // ====================
    // write channel capture
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic [2:0] wr_sel;

    assign o_axi_awready = !aw_have_q && !bvalid_q;
    assign o_axi_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q;
    assign wr_sel = reg_sel(awaddr_q);
    assign o_axi_bvalid = bvalid_q;
    assign o_axi_bresp = bresp_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (i_axi_awvalid && o_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= i_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            w_have_q <= 1'b0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (i_axi_wvalid && o_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= i_axi_wdata[7:0];
            wstrb0_q <= i_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (i_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // lane 0 carries every register; upper lanes are ignored
    logic wr_en;
    assign wr_en = wr_fire && wstrb0_q;

    // ====================
    // transmit_control_status
    logic clock_source_q;
    logic tx_nine_bit_q;
    logic tx_enable_q;
    logic sync_mode_q;
    logic high_rate_q;
    logic shift_empty_q;
    logic tx_ninth_data_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            clock_source_q <= TX_CS_RESET[TX_CLOCK_SOURCE_BIT];
            tx_nine_bit_q <= TX_CS_RESET[TX_NINE_BIT];
            tx_enable_q <= TX_CS_RESET[TX_ENABLE_BIT];
            sync_mode_q <= TX_CS_RESET[TX_SYNC_MODE_BIT];
            high_rate_q <= TX_CS_RESET[TX_HIGH_RATE_BIT];
            tx_ninth_data_q <= TX_CS_RESET[TX_NINTH_DATA_BIT];
        end else if (wr_en && wr_sel == SEL_TX_CS) begin
            clock_source_q <= wdata_q[TX_CLOCK_SOURCE_BIT];
            tx_nine_bit_q <= wdata_q[TX_NINE_BIT];
            tx_enable_q <= wdata_q[TX_ENABLE_BIT];
            sync_mode_q <= wdata_q[TX_SYNC_MODE_BIT];
            high_rate_q <= wdata_q[TX_HIGH_RATE_BIT];
            tx_ninth_data_q <= wdata_q[TX_NINTH_DATA_BIT];
        end
    end

    // read-only status sampled from the transmit engine
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            shift_empty_q <= TX_CS_RESET[TX_SHIFT_EMPTY_BIT];
        end else begin
            shift_empty_q <= i_tsr_empty;
        end
    end

    // ====================
    // receive_control_status control bits
    logic port_enable_q;
    logic rx_nine_bit_q;
    logic single_rx_q;
    logic cont_rx_q;
    logic addr_detect_q;
    logic rx_cs_wr;

    assign rx_cs_wr = wr_en && wr_sel == SEL_RX_CS;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            port_enable_q <= RX_CS_RESET[RX_PORT_ENABLE_BIT];
            rx_nine_bit_q <= RX_CS_RESET[RX_NINE_BIT];
            cont_rx_q <= RX_CS_RESET[RX_CONTINUOUS_BIT];
            addr_detect_q <= RX_CS_RESET[RX_ADDR_DETECT_BIT];
        end else if (rx_cs_wr) begin
            port_enable_q <= wdata_q[RX_PORT_ENABLE_BIT];
            rx_nine_bit_q <= wdata_q[RX_NINE_BIT];
            cont_rx_q <= wdata_q[RX_CONTINUOUS_BIT];
            addr_detect_q <= wdata_q[RX_ADDR_DETECT_BIT];
        end
    end

    // a software write in the completion cycle wins so a new request is kept
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            single_rx_q <= RX_CS_RESET[RX_SINGLE_BIT];
        end else if (rx_cs_wr) begin
            single_rx_q <= wdata_q[RX_SINGLE_BIT];
        end else if (i_rx_single_done || !port_enable_q) begin
            single_rx_q <= 1'b0;
        end
    end

    // ====================
    // mode decode toward the engines
    logic sync_master;
    logic sync_rx_active;
    logic rx_enable;

    assign sync_master = sync_mode_q && clock_source_q;
    // single receive only counts for a synchronous master
    assign sync_rx_active = sync_mode_q && (cont_rx_q || (sync_master && single_rx_q));
    assign rx_enable = port_enable_q && (cont_rx_q || (sync_master && single_rx_q));

    assign o_port_enable = port_enable_q;
    assign o_sync_mode = sync_mode_q;
    assign o_clock_master = sync_master;
    assign o_tx_enable = port_enable_q && tx_enable_q && !sync_rx_active;
    assign o_tx_nine_bit = tx_nine_bit_q;
    assign o_tx_ninth_data = tx_ninth_data_q;
    assign o_rx_enable = rx_enable;
    assign o_rx_nine_bit = rx_nine_bit_q;

    // ====================
    // two-entry receive buffer: {framing, ninth, data}
    logic [9:0] rx_mem [RX_DEPTH];
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic [1:0] rx_count_q;
    logic overrun_q;
    logic addr_reject;
    logic rx_arrive;
    logic push;
    logic pop;
    logic rd_fire;
    logic [2:0] rd_sel;
    logic [9:0] rx_top;

    // outside async nine-bit mode the detect bit has no effect
    assign addr_reject = !sync_mode_q && rx_nine_bit_q && addr_detect_q
        && !i_rx_char_ninth;
    // nothing is taken while an overrun stands
    assign rx_arrive = rx_enable && i_rx_char_valid && !addr_reject && !overrun_q;
    assign push = rx_arrive && (rx_count_q != 2'd2);
    assign rd_fire = i_axi_arvalid && o_axi_arready;
    assign rd_sel = reg_sel(i_axi_araddr);
    assign pop = rd_fire && rd_sel == SEL_RX_DATA && rx_count_q != 2'd0;
    assign rx_top = rx_mem[rd_ptr_q];

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !port_enable_q) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            rx_count_q <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            rx_count_q <= rx_count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    generate
        for (genvar gi = 0; gi < RX_DEPTH; gi++) begin : g_rx_slot
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    rx_mem[gi] <= 10'h000;
                end else if (push && wr_ptr_q == 1'(gi)) begin
                    // ninth bit is stored as received, no parity computed
                    rx_mem[gi] <= {i_rx_char_framing_error_flag, i_rx_char_ninth, i_rx_char_data};
                end
            end
        end
    endgenerate

    // the set wins over a clearing write in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !port_enable_q) begin
            overrun_q <= 1'b0;
        end else if (rx_arrive && rx_count_q == 2'd2) begin
            overrun_q <= 1'b1;
        end else if (rx_cs_wr && !wdata_q[RX_CONTINUOUS_BIT]) begin
            overrun_q <= 1'b0;
        end
    end

    assign o_receive_flag = rx_enable && rx_count_q != 2'd0;

    // ====================
    // baud generator
    logic [7:0] baud_div_q;
    logic [7:0] baud_cnt_q;
    logic div_wr;

    assign div_wr = wr_en && wr_sel == SEL_BAUD_DIV;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            baud_div_q <= BAUD_DIV_RESET;
        end else if (div_wr) begin
            baud_div_q <= wdata_q;
        end
    end

    // runs regardless of direction enables, shared by both modes
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || div_wr || !port_enable_q) begin
            baud_cnt_q <= 8'h00;
        end else if (baud_cnt_q == baud_div_q) begin
            baud_cnt_q <= 8'h00;
        end else begin
            baud_cnt_q <= baud_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || div_wr || !port_enable_q) begin
            o_baud_tick <= 1'b0;
        end else begin
            o_baud_tick <= baud_cnt_q == baud_div_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_baud_mult <= MULT_X64;
        end else if (sync_mode_q) begin
            o_baud_mult <= MULT_X4;
        end else begin
            o_baud_mult <= high_rate_q ? MULT_X16 : MULT_X64;
        end
    end

    // ====================
    // read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] rd_word;
    assign o_axi_arready = !rvalid_q;
    assign o_axi_rvalid = rvalid_q;
    assign o_axi_rdata = rdata_q;
    assign o_axi_rresp = rresp_q;

    always_comb begin
        rd_word = 8'h00;
        case (rd_sel)
            SEL_TX_CS: begin
                rd_word = {clock_source_q, tx_nine_bit_q, tx_enable_q, sync_mode_q,
                           1'b0, high_rate_q, shift_empty_q, tx_ninth_data_q};
            end
            SEL_RX_CS: begin
                // empty buffer shows framing and ninth as zero
                rd_word = {port_enable_q, rx_nine_bit_q, single_rx_q, cont_rx_q,
                           addr_detect_q,
                           rx_top[9] && rx_count_q != 2'd0,
                           overrun_q,
                           rx_top[8] && rx_count_q != 2'd0};
            end
            SEL_RX_DATA: begin
                rd_word = (rx_count_q != 2'd0) ? rx_top[7:0] : RX_DATA_RESET;
            end
            SEL_BAUD_DIV: begin
                rd_word = baud_div_q;
            end
            default: begin
                rd_word = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_word};
            rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (i_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// [include/serial_port_pkg.sv]
package serial_port_pkg;
    // ====================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_TX_CS = 8'h00;
    localparam logic [7:0] ADDR_RX_CS = 8'h04;
    localparam logic [7:0] ADDR_RX_DATA = 8'h08;
    localparam logic [7:0] ADDR_BAUD_DIV = 8'h0C;

    // ====================
    // register select codes
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_TX_CS = 3'h1;
    localparam logic [2:0] SEL_RX_CS = 3'h2;
    localparam logic [2:0] SEL_RX_DATA = 3'h3;
    localparam logic [2:0] SEL_BAUD_DIV = 3'h4;

    // ====================
    // transmit_control_status fields
    localparam int TX_CLOCK_SOURCE_BIT = 7;
    localparam int TX_NINE_BIT = 6;
    localparam int TX_ENABLE_BIT = 5;
    localparam int TX_SYNC_MODE_BIT = 4;
    localparam int TX_HIGH_RATE_BIT = 2;
    localparam int TX_SHIFT_EMPTY_BIT = 1;
    localparam int TX_NINTH_DATA_BIT = 0;
    localparam logic [7:0] TX_CS_RESET = 8'h02;

    // ====================
    // receive_control_status fields
    localparam int RX_PORT_ENABLE_BIT = 7;
    localparam int RX_NINE_BIT = 6;
    localparam int RX_SINGLE_BIT = 5;
    localparam int RX_CONTINUOUS_BIT = 4;
    localparam int RX_ADDR_DETECT_BIT = 3;
    localparam int RX_FRAMING_BIT = 2;
    localparam int RX_OVERRUN_BIT = 1;
    localparam int RX_NINTH_DATA_BIT = 0;
    localparam logic [7:0] RX_CS_RESET = 8'h00;

    localparam logic [7:0] RX_DATA_RESET = 8'h00;
    localparam logic [7:0] BAUD_DIV_RESET = 8'h00;

    // ====================
    // baud multiplier select driven to the shift engines
    localparam logic [1:0] MULT_X64 = 2'h0;
    localparam logic [1:0] MULT_X16 = 2'h1;
    localparam logic [1:0] MULT_X4 = 2'h2;

    // ====================
    // receive buffer and bus answers
    localparam int RX_DEPTH = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [dv/serial_port_props.sv]
`timescale 1ns/1ps
// ====================
// port-level checks for the serial port control block
module serial_port_props
    import serial_port_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [7:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    input wire logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    input wire logic o_axi_wready,
    input wire logic i_rx_char_valid,
    input wire logic o_port_enable,
    input wire logic o_sync_mode,
    input wire logic o_clock_master,
    input wire logic o_tx_enable,
    input wire logic o_rx_enable,
    input wire logic o_receive_flag,
    input wire logic o_baud_tick,
    input wire logic [1:0] o_baud_mult
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    // ====================
    // divisor shadow and tick spacing counters
    logic div_wr;
    logic [7:0] div_q;
    logic [2:0] wr_q;
    logic [8:0] gap_q;
    logic [8:0] since_q;
    logic clean_q;
    logic first_q;
    // limitation: address and data must be taken in the same cycle
    assign div_wr = i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready &&
        i_axi_awaddr == ADDR_BAUD_DIV && i_axi_wstrb[0];

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            div_q <= BAUD_DIV_RESET;
            wr_q <= 3'h0;
            gap_q <= 9'h0;
            since_q <= 9'h0;
            clean_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            if (div_wr) begin
                div_q <= i_axi_wdata[7:0];
            end
            wr_q <= {wr_q[1:0], div_wr};
            gap_q <= o_baud_tick ? 9'h0 : gap_q + 9'h1;
            since_q <= div_wr ? 9'h0 : (since_q == 9'h1FF ? since_q : since_q + 9'h1);
            // a few cycles after a divisor write an old tick may still be in flight
            clean_q <= !(div_wr || |wr_q) && o_port_enable && (clean_q || o_baud_tick);
            first_q <= o_port_enable &&
                (div_wr || (first_q && !(o_baud_tick && since_q > 9'h2)));
        end
    end

    // ====================
    // properties
    property p_master_sync; o_clock_master |-> o_sync_mode; endproperty
    a_master_sync: assert property (p_master_sync)
        else $error("clock master outside synchronous mode");
    property p_rx_over_tx; o_sync_mode && o_rx_enable |-> !o_tx_enable; endproperty
    a_rx_over_tx: assert property (p_rx_over_tx)
        else $error("transmitter on while synchronous receive active");
    property p_port_off;
        !o_port_enable |-> !o_tx_enable && !o_rx_enable && !o_receive_flag &&
            (!o_baud_tick || $past(o_port_enable));
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("activity while port disabled");
    property p_flag_enabled; o_receive_flag |-> o_rx_enable; endproperty
    a_flag_enabled: assert property (p_flag_enabled)
        else $error("receive flag with receiver off");
    property p_flag_cause;
        $rose(o_receive_flag) && $past(o_rx_enable) |-> $past(i_rx_char_valid);
    endproperty
    a_flag_cause: assert property (p_flag_cause)
        else $error("receive flag rose without a character");
    property p_tick_period; o_baud_tick && clean_q |-> gap_q == {1'b0, div_q}; endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("baud tick spacing differs from divisor plus one");
    property p_div_restart;
        o_baud_tick && first_q && since_q > 9'h2 |-> since_q <= {1'b0, div_q} + 9'h3;
    endproperty
    a_div_restart: assert property (p_div_restart)
        else $error("first tick after divisor write too late");
    property p_sync_mult; $stable(o_sync_mode) |-> (o_baud_mult == MULT_X4) == o_sync_mode;
    endproperty
    a_sync_mult: assert property (p_sync_mult)
        else $error("multiplier does not follow mode");

    c_tick: cover property (o_baud_tick && clean_q);
    c_flag: cover property ($rose(o_receive_flag));
    c_sync_rx: cover property (o_sync_mode && o_rx_enable);
endmodule

// [dv/serial_engine_model.sv]
`timescale 1ns/1ps
// ====================
// stand-in for the shift engines on the pin side
module serial_engine_model (
    input wire logic i_clk,
    output logic o_tsr_empty,
    output logic o_char_valid,
    output logic [7:0] o_char_data,
    output logic o_char_ninth,
    output logic o_char_framing_error_flag,
    output logic o_single_done
);
    initial begin
        o_tsr_empty = 1'b1;
        o_char_valid = 1'b0;
        o_char_data = 8'h00;
        o_char_ninth = 1'b0;
        o_char_framing_error_flag = 1'b0;
        o_single_done = 1'b0;
    end

    task automatic send(input logic [7:0] d, input logic n, input logic f);
        @(posedge i_clk);
        o_char_valid <= 1'b1;
        o_char_data <= d;
        o_char_ninth <= n;
        o_char_framing_error_flag <= f;
        @(posedge i_clk);
        // show the inverse outside the pulse
        o_char_valid <= 1'b0;
        o_char_data <= ~d;
        o_char_ninth <= ~n;
        o_char_framing_error_flag <= ~f;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic done;
        @(posedge i_clk);
        o_single_done <= 1'b1;
        @(posedge i_clk);
        o_single_done <= 1'b0;
    endtask

    task automatic set_empty(input logic v);
        o_tsr_empty <= v;
    endtask
endmodule

// [dv/serial_port_ctrl_status_brg_bench.sv]
`timescale 1ns/1ps
module serial_port_ctrl_status_brg_bench
    import serial_port_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, mult;
    logic [31:0] rdata;
    logic tsr_e, cv, cn, cf, sd;
    logic [7:0] cd;
    logic pe, sm, cm, te, t9, t9d, re, r9, rf, tick;
    int num_errors = 0;
    int checks = 0;

    always #10 clk = ~clk;

    serial_port_ctrl_status_brg DUT (
        .i_clk_sys(clk), .i_srst(rst), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
        .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
        .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
        .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_tsr_empty(tsr_e), .i_rx_char_valid(cv), .i_rx_char_data(cd),
        .i_rx_char_ninth(cn), .i_rx_char_framing_error_flag(cf), .i_rx_single_done(sd),
        .o_port_enable(pe), .o_sync_mode(sm), .o_clock_master(cm), .o_tx_enable(te),
        .o_tx_nine_bit(t9), .o_tx_ninth_data(t9d), .o_rx_enable(re), .o_rx_nine_bit(r9),
        .o_receive_flag(rf), .o_baud_tick(tick), .o_baud_mult(mult));

    serial_engine_model ENG (.i_clk(clk), .o_tsr_empty(tsr_e), .o_char_valid(cv),
        .o_char_data(cd), .o_char_ninth(cn), .o_char_framing_error_flag(cf), .o_single_done(sd));

    // ====================
    // checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // handshakes are judged at the falling edge before the edge that samples them
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh, b;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ah = awready;
            wh = wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic ah, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ah = arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
        chk(d, {24'h0, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask

    // order: port, sync, master, tx en, rx en, flag, tx nine, tx ninth, rx nine
    task automatic co(input logic [8:0] e);
        @(negedge clk);
        chk({23'h0, pe, sm, cm, te, re, rf, t9, t9d, r9}, {23'h0, e});
    endtask

    task automatic per(input int e);
        int n;
        do @(negedge clk); while (!tick);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!tick && n < 600);
        chk(n, e);
    endtask

    // ====================
    // tests
    initial begin
        int n;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_TX_CS, TX_CS_RESET, RESP_OKAY);
        rd(ADDR_RX_CS, RX_CS_RESET, RESP_OKAY);
        rd(ADDR_RX_DATA, RX_DATA_RESET, RESP_OKAY);
        rd(ADDR_BAUD_DIV, BAUD_DIV_RESET, RESP_OKAY);
        rd(8'h10, 8'h00, RESP_SLVERR);
        wr(8'h10, 8'hFF, RESP_SLVERR);
        $display("test reset values done");

        wr(ADDR_TX_CS, 8'hFF, RESP_OKAY);
        rd(ADDR_TX_CS, 8'hF7, RESP_OKAY);
        ENG.set_empty(1'b0);
        rd(ADDR_TX_CS, 8'hF5, RESP_OKAY);
        co(9'h0C6);
        chk({30'h0, mult}, {30'h0, MULT_X4});
        wr(ADDR_RX_CS, 8'h80, RESP_OKAY);
        co(9'h1E6);
        wr(ADDR_RX_CS, 8'h90, RESP_OKAY);
        co(9'h1D6);
        wr(ADDR_RX_CS, 8'hA0, RESP_OKAY);
        co(9'h1D6);
        ENG.done();
        co(9'h1E6);
        rd(ADDR_RX_CS, 8'h80, RESP_OKAY);
        wr(ADDR_TX_CS, 8'h34, RESP_OKAY);
        wr(ADDR_RX_CS, 8'hA0, RESP_OKAY);
        co(9'h1A0);
        chk({30'h0, mult}, {30'h0, MULT_X4});
        wr(ADDR_TX_CS, 8'h04, RESP_OKAY);
        co(9'h100);
        chk({30'h0, mult}, {30'h0, MULT_X16});
        wr(ADDR_TX_CS, 8'h20, RESP_OKAY);
        co(9'h120);
        chk({30'h0, mult}, {30'h0, MULT_X64});
        $display("test control bits done");

        wr(ADDR_RX_CS, 8'h90, RESP_OKAY);
        ENG.send(8'h5A, 1'b0, 1'b1);
        chk({31'h0, rf}, 32'h1);
        rd(ADDR_RX_CS, 8'h94, RESP_OKAY);
        ENG.send(8'hA5, 1'b0, 1'b0);
        ENG.send(8'h3C, 1'b0, 1'b0);
        rd(ADDR_RX_CS, 8'h96, RESP_OKAY);
        rd(ADDR_RX_DATA, 8'h5A, RESP_OKAY);
        rd(ADDR_RX_CS, 8'h92, RESP_OKAY);
        rd(ADDR_RX_DATA, 8'hA5, RESP_OKAY);
        ENG.send(8'h11, 1'b0, 1'b0);
        chk({31'h0, rf}, 32'h0);
        rd(ADDR_RX_CS, 8'h92, RESP_OKAY);
        wr(ADDR_RX_CS, 8'h80, RESP_OKAY);
        rd(ADDR_RX_CS, 8'h80, RESP_OKAY);
        wr(ADDR_RX_CS, 8'h90, RESP_OKAY);
        ENG.send(8'h11, 1'b0, 1'b0);
        rd(ADDR_RX_DATA, 8'h11, RESP_OKAY);
        $display("test receive buffer done");

        wr(ADDR_RX_CS, 8'hD8, RESP_OKAY);
        ENG.send(8'h22, 1'b0, 1'b0);
        chk({31'h0, rf}, 32'h0);
        ENG.send(8'h33, 1'b1, 1'b0);
        chk({31'h0, r9}, 32'h1);
        rd(ADDR_RX_CS, 8'hD9, RESP_OKAY);
        rd(ADDR_RX_DATA, 8'h33, RESP_OKAY);
        wr(ADDR_RX_CS, 8'hD0, RESP_OKAY);
        ENG.send(8'h44, 1'b0, 1'b0);
        rd(ADDR_RX_CS, 8'hD0, RESP_OKAY);
        rd(ADDR_RX_DATA, 8'h44, RESP_OKAY);
        $display("test nine bit done");

        wr(ADDR_BAUD_DIV, 8'h03, RESP_OKAY);
        per(4);
        wr(ADDR_BAUD_DIV, 8'h09, RESP_OKAY);
        per(10);
        rd(ADDR_BAUD_DIV, 8'h09, RESP_OKAY);
        wstrb <= 4'h0;
        wr(ADDR_BAUD_DIV, 8'h55, RESP_OKAY);
        wstrb <= 4'hF;
        rd(ADDR_BAUD_DIV, 8'h09, RESP_OKAY);
        wr(ADDR_RX_CS, 8'h00, RESP_OKAY);
        n = 0;
        repeat (30) begin
            @(negedge clk);
            n += int'(tick);
        end
        chk(n, 0);
        $display("test baud generator done");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule

bind serial_port_ctrl_status_brg serial_port_props PROPS (
    .i_clk_sys, .i_srst, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
    .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .i_rx_char_valid, .o_port_enable,
    .o_sync_mode, .o_clock_master, .o_tx_enable, .o_rx_enable, .o_receive_flag,
    .o_baud_tick, .o_baud_mult);
